// File: parallel_program_port.v
// Purpose: Parallel programming port: entry, loads, page writes, erase, fuses, locks, reads.
// Assumes: Pins synchronous to clk_i; high voltage on reset shown by hv_reset_i.
// Notes: Write and erase times are parameters; memories are simple arrays.
`timescale 1ns/10ps
`include "ppp_consts.vh"

// Operation
// - Entry pins changing within 100 ns of high voltage abort entry.
// - Command and address registers persist across operations.
// - Erase clears program, data memory, then lock bits; fuses untouched.
// - Keep-data fuse programmed preserves data memory during erase.
// - Command 80 plus write pulse starts erase; busy low until done.
// - Action 10 with byte-select-low 0 loads command from data bus.
// - Action 00 loads address byte: low, high or extended by byte select.
// - Action 01 loads data low or high byte by byte-select-low.
// - Page latch pulse with byte-select-low 1 stores word in page buffer.
// - Command 10 selects program memory page write.
// - Low address bits pick word; upper bits pick page.
// - Write pulse with byte select 00 programs page; busy low meanwhile.
// - No-operation command ends page programming and clears write controls.
// - Command 11 selects data memory page write, busy low while writing.
// - Commands 02 and 03 read program or data memory while output enable low.
// - Command 40 writes fuse byte low, high or extended from data low byte.
// - Command 20 writes lock bits; full lock blocks boot lock programming.
// - Only chip erase unprograms lock bits.
// - Ready flag low while busy, high when ready.
// - Data bus driven only while output enable low.
module parallel_program_port #(
  parameter PAGE_BITS = 7,
  parameter PROG_BITS = 14,
  parameter DPAGE_BITS = 3,
  parameter DATA_BITS = 10,
  parameter WRITE_CYCLES = 370000,
  parameter ERASE_CYCLES = 750000
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire hv_reset_i,
  input wire load_strobe_i,
  input wire action_select_0_i,
  input wire action_select_1_i,
  input wire byte_select_low_bit_i,
  input wire byte_select_high_bit_i,
  input wire page_latch_strobe_i,
  input wire write_n_i,
  input wire output_enable_n_i,
  input wire [7:0] data_i,
  output wire [7:0] data_o,
  output wire data_oe_o,
  output wire ready_busy_flag_o,
  output wire prog_mode_o,
  output wire [7:0] fuse_low_o,
  output wire [7:0] fuse_high_o,
  output wire [7:0] fuse_ext_o,
  output wire [7:0] lock_bits_o
);
  localparam GUARD_CYC = (`ENTRY_GUARD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam ST_OFF = 3'd0;
  localparam ST_ARMED = 3'd1;
  localparam ST_GUARD = 3'd2;
  localparam ST_IDLE = 3'd3;
  localparam ST_WRITE = 3'd4;
  localparam ST_ERASE = 3'd5;
  localparam ST_WAIT = 3'd6;
  localparam CW = 20;

  // ----------------------------------------
  // Strobe synchronisers
  // ----------------------------------------
  wire ld_rise;
  wire pl_rise;
  wire wr_fall;
  wire hv_lvl;
  wire hv_rise;

  ppp_sync u_ld (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .level_i(load_strobe_i),
    .rst_val_i(1'b0), .level_o(), .rise_o(ld_rise), .fall_o());
  ppp_sync u_pl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .level_i(page_latch_strobe_i),
    .rst_val_i(1'b0), .level_o(), .rise_o(pl_rise), .fall_o());
  ppp_sync u_wr (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .level_i(write_n_i),
    .rst_val_i(1'b1), .level_o(), .rise_o(), .fall_o(wr_fall));
  ppp_sync u_hv (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .level_i(hv_reset_i),
    .rst_val_i(1'b0), .level_o(hv_lvl), .rise_o(hv_rise), .fall_o());

  wire [1:0] act = {action_select_1_i, action_select_0_i};
  wire [1:0] bsel = {byte_select_high_bit_i, byte_select_low_bit_i};
  wire [3:0] entry_pins = {page_latch_strobe_i, action_select_1_i,
    action_select_0_i, byte_select_low_bit_i};

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [2:0] state_r;
  reg [2:0] pulse_cnt_r;
  reg [3:0] entry_snap_r;
  reg [7:0] guard_r;
  reg [CW-1:0] busy_r;
  reg [7:0] cmd_r;
  reg [7:0] addr_lo_r;
  reg [7:0] addr_hi_r;
  reg [7:0] addr_ext_r;
  reg [7:0] data_lo_r;
  reg [7:0] data_hi_r;
  reg [7:0] fuse_low_r;
  reg [7:0] fuse_high_r;
  reg [7:0] fuse_ext_r;
  reg [7:0] lock_r;
  reg [PROG_BITS-1:0] erase_ptr_r;
  reg page_dirty_r;
  reg [PAGE_BITS:0] copy_ptr_r;
  reg copy_data_r;

  wire in_prog = (state_r == ST_IDLE) || (state_r == ST_WRITE) || (state_r == ST_ERASE);
  wire idle = (state_r == ST_IDLE);
  wire [15:0] word_addr = {addr_hi_r, addr_lo_r};

  // ----------------------------------------
  // Memories: page buffers and arrays
  // ----------------------------------------
  wire copying = (state_r == ST_WRITE) && (copy_ptr_r[PAGE_BITS] == 1'b0);
  wire erasing = (state_r == ST_ERASE);
  wire [PAGE_BITS-1:0] copy_word = copy_ptr_r[PAGE_BITS-1:0];
  wire latch_ok = idle && pl_rise && byte_select_low_bit_i;
  wire [PAGE_BITS-1:0] pbuf_addr = copying ? copy_word
    : word_addr[PAGE_BITS-1:0];
  wire [DPAGE_BITS-1:0] dbuf_addr = copying ? copy_word[DPAGE_BITS-1:0]
    : word_addr[DPAGE_BITS-1:0];
  wire [15:0] pbuf_q;
  wire [7:0] dbuf_q;
  wire prog_copy = copying && !copy_data_r;
  wire data_copy = copying && copy_data_r &&
    (copy_word < (1 << DPAGE_BITS));
  // Page number from upper address bits, word within page from the copy pointer.
  wire [PROG_BITS-1:0] prog_waddr = {word_addr[PROG_BITS-1:PAGE_BITS], copy_word};
  wire [DATA_BITS-1:0] data_waddr = {word_addr[DATA_BITS-1:DPAGE_BITS],
    copy_word[DPAGE_BITS-1:0]};
  wire [PROG_BITS-1:0] prog_addr = erasing ? erase_ptr_r
    : (copying ? prog_waddr : word_addr[PROG_BITS-1:0]);
  wire [DATA_BITS-1:0] data_addr = erasing ? erase_ptr_r[DATA_BITS-1:0]
    : (copying ? data_waddr : word_addr[DATA_BITS-1:0]);
  wire keep_data = ~fuse_high_r[`KEEP_DATA_BIT];
  wire [15:0] prog_q;
  wire [7:0] data_q;

  ppp_mem #(.AW(PAGE_BITS), .DW(16)) u_pbuf (.clk_i(clk_i),
    .we_i(latch_ok && cmd_r == `CMD_WR_PROG), .addr_i(pbuf_addr),
    .wdata_i({data_hi_r, data_lo_r}), .rdata_o(pbuf_q));
  ppp_mem #(.AW(DPAGE_BITS), .DW(8)) u_dbuf (.clk_i(clk_i),
    .we_i(latch_ok && cmd_r == `CMD_WR_DATA), .addr_i(dbuf_addr),
    .wdata_i(data_lo_r), .rdata_o(dbuf_q));
  // Read data lags a cycle, so copy writes use the buffer word from the previous pointer.
  reg [PROG_BITS-1:0] prog_waddr_d_r;
  reg [DATA_BITS-1:0] data_waddr_d_r;
  reg prog_copy_d_r;
  reg data_copy_d_r;
  ppp_mem #(.AW(PROG_BITS), .DW(16)) u_prog (.clk_i(clk_i),
    .we_i(erasing || prog_copy_d_r),
    .addr_i(prog_copy_d_r ? prog_waddr_d_r : prog_addr),
    .wdata_i(erasing ? {`ERASED_BYTE, `ERASED_BYTE} : pbuf_q), .rdata_o(prog_q));
  ppp_mem #(.AW(DATA_BITS), .DW(8)) u_data (.clk_i(clk_i),
    .we_i((erasing && !keep_data) || data_copy_d_r),
    .addr_i(data_copy_d_r ? data_waddr_d_r : data_addr),
    .wdata_i(erasing ? `ERASED_BYTE : dbuf_q), .rdata_o(data_q));

  // ----------------------------------------
  // Control sequencer
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_OFF;
      pulse_cnt_r <= 3'd0;
      entry_snap_r <= 4'h0;
      guard_r <= 8'h00;
      busy_r <= {CW{1'b0}};
      cmd_r <= `CMD_NOP;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      addr_ext_r <= 8'h00;
      data_lo_r <= 8'h00;
      data_hi_r <= 8'h00;
      fuse_low_r <= `FUSE_LOW_RST;
      fuse_high_r <= `FUSE_HIGH_RST;
      fuse_ext_r <= `FUSE_EXT_RST;
      lock_r <= `LOCK_RST;
      erase_ptr_r <= {PROG_BITS{1'b0}};
      page_dirty_r <= 1'b0;
      copy_ptr_r <= {(PAGE_BITS+1){1'b0}};
      copy_data_r <= 1'b0;
      prog_copy_d_r <= 1'b0;
      data_copy_d_r <= 1'b0;
      prog_waddr_d_r <= {PROG_BITS{1'b0}};
      data_waddr_d_r <= {DATA_BITS{1'b0}};
    end else begin
      prog_copy_d_r <= prog_copy;
      data_copy_d_r <= data_copy;
      prog_waddr_d_r <= prog_waddr;
      data_waddr_d_r <= data_waddr;
      if (!hv_lvl && state_r >= ST_GUARD) begin
        state_r <= ST_OFF;
        pulse_cnt_r <= 3'd0;
      end else begin
        case (state_r)
          ST_OFF: begin
            if (ld_rise && pulse_cnt_r != 3'd7) begin
              pulse_cnt_r <= pulse_cnt_r + 3'd1;
            end
            if (hv_rise && pulse_cnt_r >= `ENTRY_PULSES &&
                entry_pins == 4'h0) begin
              state_r <= ST_GUARD;
              entry_snap_r <= entry_pins;
              guard_r <= 8'h00;
            end
          end
          ST_GUARD: begin
            if (entry_pins != entry_snap_r) begin
              state_r <= ST_WAIT;
            end else if (guard_r == GUARD_CYC[7:0]) begin
              state_r <= ST_IDLE;
            end else begin
              guard_r <= guard_r + 8'h01;
            end
          end
          ST_WAIT: begin
            // Entry failed; stay out until high voltage drops.
            state_r <= ST_WAIT;
          end
          ST_IDLE: begin
            if (ld_rise) begin
              case (act)
                `ACT_CMD: begin
                  if (!byte_select_low_bit_i) begin
                    cmd_r <= data_i;
                    if (data_i == `CMD_NOP) begin
                      page_dirty_r <= 1'b0;
                    end
                  end
                end
                `ACT_ADDR: begin
                  if (bsel == `BSEL_LOW) begin
                    addr_lo_r <= data_i;
                  end else if (bsel == `BSEL_HIGH) begin
                    addr_hi_r <= data_i;
                  end else if (bsel == `BSEL_EXT) begin
                    addr_ext_r <= data_i;
                  end
                end
                `ACT_DATA: begin
                  if (byte_select_low_bit_i) begin
                    data_hi_r <= data_i;
                  end else begin
                    data_lo_r <= data_i;
                  end
                end
                default: begin
                  cmd_r <= cmd_r;
                end
              endcase
            end
            if (latch_ok) begin
              page_dirty_r <= 1'b1;
            end
            if (wr_fall) begin
              case (cmd_r)
                `CMD_ERASE: begin
                  state_r <= ST_ERASE;
                  erase_ptr_r <= {PROG_BITS{1'b0}};
                  busy_r <= ERASE_CYCLES[CW-1:0];
                end
                `CMD_WR_PROG, `CMD_WR_DATA: begin
                  if (bsel == `BSEL_LOW) begin
                    state_r <= ST_WRITE;
                    copy_ptr_r <= {(PAGE_BITS+1){1'b0}};
                    copy_data_r <= (cmd_r == `CMD_WR_DATA);
                    busy_r <= WRITE_CYCLES[CW-1:0];
                  end
                end
                `CMD_FUSE: begin
                  state_r <= ST_WRITE;
                  copy_ptr_r <= {1'b1, {PAGE_BITS{1'b0}}};
                  busy_r <= WRITE_CYCLES[CW-1:0];
                  if (bsel == `BSEL_LOW) begin
                    fuse_low_r <= data_lo_r;
                  end else if (bsel == `BSEL_HIGH) begin
                    fuse_high_r <= data_lo_r;
                  end else if (bsel == `BSEL_EXT) begin
                    fuse_ext_r <= data_lo_r;
                  end
                end
                `CMD_LOCK: begin
                  state_r <= ST_WRITE;
                  copy_ptr_r <= {1'b1, {PAGE_BITS{1'b0}}};
                  busy_r <= WRITE_CYCLES[CW-1:0];
                  // AND only ever programs bits, so no write unprograms a lock.
                  if (!lock_r[`LOCK_ONE_BIT] && !lock_r[`LOCK_TWO_BIT]) begin
                    lock_r <= lock_r & (data_lo_r | `LOCK_BOOT_MASK);
                  end else begin
                    lock_r <= lock_r & data_lo_r;
                  end
                end
                default: begin
                  state_r <= ST_IDLE;
                end
              endcase
            end
          end
          ST_WRITE: begin
            if (copying) begin
              copy_ptr_r <= copy_ptr_r + 1'b1;
            end
            if (busy_r <= 1 && !copying) begin
              state_r <= ST_IDLE;
            end else if (busy_r > 1) begin
              busy_r <= busy_r - 1'b1;
            end
          end
          ST_ERASE: begin
            if (erase_ptr_r != {PROG_BITS{1'b1}}) begin
              erase_ptr_r <= erase_ptr_r + 1'b1;
            end
            if (busy_r <= 1 && erase_ptr_r == {PROG_BITS{1'b1}}) begin
              lock_r <= `LOCK_RST;
              state_r <= ST_IDLE;
            end else if (busy_r > 1) begin
              busy_r <= busy_r - 1'b1;
            end
          end
          default: begin
            state_r <= ST_OFF;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read path and pins
  // ----------------------------------------
  reg [7:0] rd_r;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_r <= 8'h00;
    end else if (cmd_r == `CMD_RD_PROG) begin
      rd_r <= byte_select_low_bit_i ? prog_q[15:8] : prog_q[7:0];
    end else if (cmd_r == `CMD_RD_DATA) begin
      rd_r <= data_q;
    end else begin
      rd_r <= 8'h00;
    end
  end

  assign data_o = rd_r;
  assign data_oe_o = in_prog && !output_enable_n_i;
  assign ready_busy_flag_o = !(state_r == ST_WRITE || state_r == ST_ERASE);
  assign prog_mode_o = in_prog;
  assign fuse_low_o = fuse_low_r;
  assign fuse_high_o = fuse_high_r;
  assign fuse_ext_o = fuse_ext_r;
  assign lock_bits_o = lock_r;
endmodule // parallel_program_port

// File: ppp_chk.sv
// Purpose: Pin-level assertions for the parallel program port.
// Assumes: One clock, synchronous active-high reset.
// Notes: The loaded command is not visible here, so checks tie pins to each other.
`timescale 1ns/10ps
module ppp_chk #(
  parameter ERASE_CYCLES = 750000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic write_n_i,
  input wire logic output_enable_n_i,
  input wire logic data_oe_o,
  input wire logic ready_busy_flag_o,
  input wire logic prog_mode_o,
  input wire logic [7:0] fuse_low_o,
  input wire logic [7:0] fuse_high_o,
  input wire logic [7:0] fuse_ext_o,
  input wire logic [7:0] lock_bits_o
);
  // Erase never runs shorter than 2^14 cycles, so the bound takes the larger figure.
  localparam int BUSY_MAX = (ERASE_CYCLES > 16384 ? ERASE_CYCLES : 16384) + 16;
  logic [31:0] busy_cnt_r;
  logic [23:0] fuses;
  assign fuses = {fuse_low_o, fuse_high_o, fuse_ext_o};
  always @(posedge clk_i) begin
    if (sys_rst_i || ready_busy_flag_o) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_bus_drive: assert property (data_oe_o == (prog_mode_o && !output_enable_n_i))
    else $error("data bus drive does not follow output enable");
  chk_busy_cause: assert property ($fell(ready_busy_flag_o) |-> !$past(write_n_i, 3))
    else $error("busy began without a write pulse");
  chk_busy_min: assert property ($fell(ready_busy_flag_o) |-> !ready_busy_flag_o [*8])
    else $error("busy ended too early");
  chk_busy_bound: assert property (busy_cnt_r <= BUSY_MAX)
    else $error("busy lasted too long");
  chk_idle_ready: assert property (!prog_mode_o |-> ready_busy_flag_o)
    else $error("busy outside programming mode");
  chk_fuse_prog: assert property ($changed(fuses) |-> prog_mode_o)
    else $error("fuse changed outside programming mode");
  chk_lock_clear: assert property (|(~$past(lock_bits_o) & lock_bits_o) |-> lock_bits_o == 8'hFF)
    else $error("lock bit cleared without erase");
  chk_boot_guard: assert property (($past(lock_bits_o[1:0]) == 2'b00 && lock_bits_o != 8'hFF)
    |-> lock_bits_o[5:2] == $past(lock_bits_o[5:2]))
    else $error("boot lock changed under full lock");
  chk_erase_fuse: assert property (($changed(lock_bits_o) && lock_bits_o == 8'hFF) |-> $stable(fuses))
    else $error("fuses changed during erase");
  cov_busy: cover property ($fell(ready_busy_flag_o));
  cov_read: cover property (data_oe_o);
  cov_unlock: cover property ($changed(lock_bits_o) && lock_bits_o == 8'hFF);
endmodule // ppp_chk

bind parallel_program_port ppp_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .write_n_i(write_n_i),
  .output_enable_n_i(output_enable_n_i),
  .data_oe_o(data_oe_o),
  .ready_busy_flag_o(ready_busy_flag_o),
  .prog_mode_o(prog_mode_o),
  .fuse_low_o(fuse_low_o),
  .fuse_high_o(fuse_high_o),
  .fuse_ext_o(fuse_ext_o),
  .lock_bits_o(lock_bits_o)
);

// File: ppp_consts.vh
// Purpose: Constants for the parallel program port.
// Assumes: 100 MHz clock, strobes synchronous to clk_i.
// Notes: Definitions only.
`ifndef PPP_CONSTS_VH
`define PPP_CONSTS_VH
// ----------------------------------------
// Action select and byte select codes
// ----------------------------------------
`define ACT_ADDR 2'b00
`define ACT_DATA 2'b01
`define ACT_CMD 2'b10
`define ACT_IDLE 2'b11
`define BSEL_LOW 2'b00
`define BSEL_HIGH 2'b01
`define BSEL_EXT 2'b10
// ----------------------------------------
// Command bytes
// ----------------------------------------
`define CMD_NOP 8'h00
`define CMD_ERASE 8'h80
`define CMD_FUSE 8'h40
`define CMD_LOCK 8'h20
`define CMD_WR_PROG 8'h10
`define CMD_WR_DATA 8'h11
`define CMD_RD_PROG 8'h02
`define CMD_RD_DATA 8'h03
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define ERASED_BYTE 8'hFF
`define FUSE_LOW_RST 8'h5E
`define FUSE_HIGH_RST 8'h99
`define FUSE_EXT_RST 8'hF3
`define LOCK_RST 8'hFF
`define KEEP_DATA_BIT 3
`define LOCK_ONE_BIT 0
`define LOCK_TWO_BIT 1
`define LOCK_BOOT_MASK 8'h3C
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define ENTRY_GUARD_NS 100
`define ENTRY_PULSES 6
`endif

// File: ppp_mem.v
// Purpose: Single port memory of DW-bit words with registered read data.
// Assumes: One access per cycle.
// Notes: Used for program memory, data memory and page buffers.
`timescale 1ns/10ps
module ppp_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // ppp_mem

// File: ppp_programmer.sv
// Purpose: Behavioural external programmer driving the port pins.
// Assumes: Pins change at the falling clock edge.
// Notes: Pins stay put through each strobe so the two-flop sampling sees them settled.
`timescale 1ns/10ps
`include "ppp_consts.vh"
module ppp_programmer (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic ready_busy_flag_i,
  output logic hv_reset_o,
  output logic load_strobe_o,
  output logic [1:0] act_o,
  output logic [1:0] bsel_o,
  output logic page_latch_o,
  output logic write_n_o,
  output logic output_enable_n_o,
  output logic [7:0] data_o
);
  initial begin
    hv_reset_o = 1'b0;
    load_strobe_o = 1'b0;
    act_o = `ACT_IDLE;
    bsel_o = `BSEL_LOW;
    page_latch_o = 1'b0;
    write_n_o = 1'b1;
    output_enable_n_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic enter(input logic abort);
    hv_reset_o = 1'b0;
    // The drop must clear the synchroniser first, or the first strobe is lost.
    tick(4);
    repeat (6) begin
      load_strobe_o = 1'b1;
      tick(2);
      load_strobe_o = 1'b0;
      tick(2);
    end
    act_o = 2'b00;
    bsel_o[0] = 1'b0;
    page_latch_o = 1'b0;
    tick(12);
    hv_reset_o = 1'b1;
    if (abort) begin
      tick(3);
      act_o[0] = 1'b1;
      tick(2);
      act_o[0] = 1'b0;
    end
    tick(25);
    if (!abort) begin
      tick(5000);
    end
  endtask
  task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
    tick(1);
    act_o = act;
    bsel_o = bs;
    data_o = d;
    tick(1);
    load_strobe_o = 1'b1;
    tick(4);
    load_strobe_o = 1'b0;
    tick(4);
  endtask
  task automatic latch();
    tick(1);
    bsel_o[0] = 1'b1;
    tick(1);
    page_latch_o = 1'b1;
    tick(4);
    page_latch_o = 1'b0;
    tick(4);
  endtask
  task automatic pulse(input logic [1:0] bs, output logic busy_seen);
    int n;
    busy_seen = 1'b0;
    tick(1);
    bsel_o = bs;
    tick(1);
    write_n_o = 1'b0;
    tick(6);
    write_n_o = 1'b1;
    // Nothing new is sent until ready returns, bounded past the erase time.
    for (n = 0; n < 30000 && !(busy_seen && ready_busy_flag_i === 1'b1); n++) begin
      if (ready_busy_flag_i === 1'b0) begin
        busy_seen = 1'b1;
      end
      tick(1);
    end
  endtask
  task automatic read(input logic bs_low, output logic [7:0] v);
    tick(1);
    bsel_o = {1'b0, bs_low};
    // Released lines show the inverse so a silent device cannot pass for a match.
    data_o = ~data_o;
    output_enable_n_o = 1'b0;
    tick(4);
    v = bus_i;
    output_enable_n_o = 1'b1;
    tick(2);
  endtask
endmodule // ppp_programmer

// File: ppp_sync.v
// Purpose: Synchroniser with single-cycle edge pulses.
// Assumes: Input changes slower than the clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module ppp_sync (
  input wire clk_i,
  input wire sys_rst_i,
  input wire level_i,
  input wire rst_val_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_r;
  reg sync_r;
  reg last_r;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      // Resetting to the pin's idle level keeps a false edge from following reset.
      meta_r <= rst_val_i;
      sync_r <= rst_val_i;
      last_r <= rst_val_i;
    end else begin
      meta_r <= level_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~last_r;
  assign fall_o = ~sync_r & last_r;
endmodule // ppp_sync

// File: testbench.sv
// Purpose: Self-checking bench for the parallel program port.
// Assumes: Write and erase times shortened by parameters.
// Notes: The programmer model drives all pins at the falling edge.
`timescale 1ns/10ps
`include "ppp_consts.vh"
module testbench;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hv, ls, pl, wn, oen, oe, rdy, pm, seen;
  logic [1:0] act, bsel;
  logic [7:0] pdat, ddat, bus, fl, fh, fe, lk, v;
  int mismatches = 0;
  int checks_done = 0;
  assign bus = oe ? ddat : pdat;
  always #5 clk_i = ~clk_i;
  parallel_program_port #(.WRITE_CYCLES(50), .ERASE_CYCLES(20000)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hv_reset_i(hv), .load_strobe_i(ls),
    .action_select_0_i(act[0]), .action_select_1_i(act[1]),
    .byte_select_low_bit_i(bsel[0]), .byte_select_high_bit_i(bsel[1]),
    .page_latch_strobe_i(pl), .write_n_i(wn), .output_enable_n_i(oen), .data_i(bus),
    .data_o(ddat), .data_oe_o(oe), .ready_busy_flag_o(rdy), .prog_mode_o(pm),
    .fuse_low_o(fl), .fuse_high_o(fh), .fuse_ext_o(fe), .lock_bits_o(lk)
  );
  ppp_programmer u_prog (
    .clk_i(clk_i), .bus_i(bus), .ready_busy_flag_i(rdy), .hv_reset_o(hv),
    .load_strobe_o(ls), .act_o(act), .bsel_o(bsel), .page_latch_o(pl),
    .write_n_o(wn), .output_enable_n_o(oen), .data_o(pdat)
  );
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_word(input logic [7:0] lo, input logic [15:0] w);
    u_prog.load(`ACT_ADDR, `BSEL_LOW, lo);
    u_prog.load(`ACT_DATA, `BSEL_LOW, w[7:0]);
    u_prog.load(`ACT_DATA, `BSEL_HIGH, w[15:8]);
    u_prog.latch();
    u_prog.pulse(`BSEL_LOW, seen);
    chk("page busy", 8'h01, {7'h0, seen});
  endtask
  task automatic rd_word(input logic [7:0] lo, input logic [15:0] w);
    u_prog.load(`ACT_ADDR, `BSEL_LOW, lo);
    u_prog.read(1'b0, v);
    chk("flash low", w[7:0], v);
    u_prog.read(1'b1, v);
    chk("flash high", w[15:8], v);
  endtask
  task automatic t_reset();
    chk("fuse low", `FUSE_LOW_RST, fl);
    chk("fuse high", `FUSE_HIGH_RST, fh);
    chk("fuse ext", `FUSE_EXT_RST, fe);
    chk("lock", `LOCK_RST, lk);
    chk("idle pins", 8'h04, {5'h0, rdy, pm, oe});
  endtask
  task automatic t_entry();
    u_prog.enter(1'b1);
    chk("aborted entry", 8'h00, {7'h0, pm});
    u_prog.enter(1'b0);
    chk("entry", 8'h01, {7'h0, pm});
  endtask
  task automatic t_flash();
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_WR_PROG);
    u_prog.load(`ACT_ADDR, `BSEL_HIGH, 8'h00);
    wr_word(8'h05, 16'h1234);
    wr_word(8'h85, 16'hABCD);
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_NOP);
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_RD_PROG);
    rd_word(8'h05, 16'h1234);
    rd_word(8'h85, 16'hABCD);
    u_prog.load(`ACT_IDLE, `BSEL_LOW, 8'h05);
    u_prog.read(1'b0, v);
    chk("idle load", 8'hCD, v);
    chk("bus released", 8'h00, {7'h0, oe});
  endtask
  task automatic t_eeprom();
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_WR_DATA);
    u_prog.load(`ACT_ADDR, `BSEL_LOW, 8'h03);
    u_prog.load(`ACT_DATA, `BSEL_LOW, 8'hA5);
    u_prog.latch();
    u_prog.pulse(`BSEL_LOW, seen);
    chk("data busy", 8'h01, {7'h0, seen});
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_RD_DATA);
    u_prog.read(1'b0, v);
    chk("data read", 8'hA5, v);
  endtask
  task automatic t_fuse();
    int i;
    logic [7:0] want [0:2];
    want[0] = 8'h6A;
    want[1] = 8'h91;
    want[2] = 8'hF5;
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_FUSE);
    for (i = 0; i < 3; i++) begin
      u_prog.load(`ACT_DATA, `BSEL_LOW, want[i]);
      u_prog.pulse(i[1:0], seen);
    end
    chk("fuse low", want[0], fl);
    chk("fuse high", want[1], fh);
    chk("fuse ext", want[2], fe);
  endtask
  task automatic t_lock();
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_LOCK);
    u_prog.load(`ACT_DATA, `BSEL_LOW, 8'hFC);
    u_prog.pulse(`BSEL_LOW, seen);
    chk("full lock", 8'hFC, lk);
    u_prog.load(`ACT_DATA, `BSEL_LOW, 8'hF3);
    u_prog.pulse(`BSEL_LOW, seen);
    chk("lock kept", 8'hFC, lk);
  endtask
  task automatic t_erase();
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_ERASE);
    u_prog.pulse(`BSEL_LOW, seen);
    chk("erase busy", 8'h01, {7'h0, seen});
    chk("lock erased", 8'hFF, lk);
    chk("fuse kept", 8'h91, fh);
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_RD_DATA);
    u_prog.read(1'b0, v);
    chk("data kept", 8'hA5, v);
    u_prog.load(`ACT_CMD, `BSEL_LOW, `CMD_RD_PROG);
    u_prog.read(1'b0, v);
    chk("flash erased", 8'hFF, v);
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_entry();
    t_flash();
    t_eeprom();
    t_fuse();
    t_lock();
    t_erase();
    end_sim();
  end
  initial begin
    #1000000;
    mismatches++;
    $display("BAD watchdog expected finish seen timeout");
    end_sim();
  end
endmodule // testbench
